/* rtl/ship_switch_power_ctrl.v */
// ship switch and power reset controller with serial slave and register bus
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "ship_switch_power_ctrl_defs.vh"
// Function
// R1 - mode 00 default: switch on, serial on
// R2 - mode 01: all off, serial off, shutdown
// R3 - mode 10: switches off, serial on, slow clock
// R4 - ship exit: plug, write 00, reset, button
// R5 - mode 11: switch off 350ms, then 00
// R6 - power reset leaves battery switch unchanged
// R7 - leaving 00: switch off now or 10s
// R8 - write 01 with adapter returns 00
// R9 - write 10 with adapter returns 00
// R10 - leaving shutdown restores field to 00
// R11 - button low 10s starts power reset
// R12 - discharge sink on during power reset
// R13 - power reset works with or without adapter
// R14 - serial slave answers at address 0x6b
// R15 - reads above 0x25 return 0xff
// R16 - serial rates up to 400 kbit/s
// R17 - data changes only while clock low
// R18 - master frames with start and stop
// R19 - bytes 8 bits, msb first, then ack
// R20 - slave may stretch clock between bytes
// R21 - undefined offset gets nack, back idle
// R22 - multi-byte access, pointer auto-increments
// R23 - register reset bit clears itself
// R24 - direction bit: 0 write, 1 read
// R25 - button low timed, restarts on high
// R26 - stop or start resets serial slave
module ship_switch_power_ctrl #(
  parameter [27:0] OFF_WAIT_CYC = `OFF_WAIT_MS * `CLK_KHZ,
  parameter [27:0] EXIT_LONG_CYC = `EXIT_LONG_MS * `CLK_KHZ,
  parameter [27:0] EXIT_SHORT_CYC = `EXIT_SHORT_MS * `CLK_KHZ,
  parameter [27:0] PRESET_CYC = `PRESET_OFF_MS * `CLK_KHZ,
  parameter [27:0] BTN_RST_CYC = `BTN_RST_MS * `CLK_KHZ
) (
  input wire aclk, // 20 MHz clock
  input wire aresetn, // synchronous reset, low active
  input wire [3:0] awaddr, // write address
  input wire awvalid, // write address valid
  output reg awready, // write address ready
  input wire [31:0] wdata, // write data
  input wire [3:0] wstrb, // write byte strobes
  input wire wvalid, // write data valid
  output reg wready, // write data ready
  output reg [1:0] bresp, // write response
  output reg bvalid, // write response valid
  input wire bready, // write response ready
  input wire [3:0] araddr, // read address
  input wire arvalid, // read address valid
  output reg arready, // read address ready
  output reg [31:0] rdata, // read data
  output reg [1:0] rresp, // read response
  output reg rvalid, // read data valid
  input wire rready, // read data ready
  input wire scl_i, // serial clock pin level
  input wire sda_i, // serial data pin level
  output reg sda_o, // serial data drive level, always low
  output reg sda_oe_n, // low while pulling data line low
  input wire wake_button_n, // wake button, low active
  input wire input_bus_voltage, // adapter present
  input wire charge_bat_req, // charger wants battery switch on
  output reg ship_gate_drive, // external ship switch on
  output reg internal_battery_switch, // internal battery switch on
  output reg input_high_impedance, // input held in high impedance
  output reg sys_discharge_en, // system rail sink current on
  output reg i2c_enabled, // serial slave alive
  output reg sys_clk_slow, // system clock slowed
  output reg [1:0] ship_switch_ctrl // current control field
);

  localparam [2:0] P_IDLE = 3'h0;
  localparam [2:0] P_WAIT = 3'h1;
  localparam [2:0] P_SHUT = 3'h2;
  localparam [2:0] P_SHIP = 3'h3;
  localparam [2:0] P_RST = 3'h4;

  localparam [2:0] I_IDLE = 3'h0;
  localparam [2:0] I_ADDR = 3'h1;
  localparam [2:0] I_PTR = 3'h2;
  localparam [2:0] I_WDATA = 3'h3;
  localparam [2:0] I_ACK = 3'h4;
  localparam [2:0] I_RDATA = 3'h5;
  localparam [2:0] I_RACK = 3'h6;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg scl_s1_q, scl_s2_q, scl_s3_q;
  reg sda_s1_q, sda_s2_q, sda_s3_q;
  reg btn_s1_q, btn_s2_q;
  reg input_bus_voltage_s1_q, input_bus_voltage_s2_q, input_bus_voltage_s3_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      {btn_s1_q, btn_s2_q} <= 2'h3;
      {input_bus_voltage_s1_q, input_bus_voltage_s2_q, input_bus_voltage_s3_q} <= 3'h0;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_i, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_i, sda_s1_q, sda_s2_q};
      {btn_s1_q, btn_s2_q} <= {wake_button_n, btn_s1_q};
      {input_bus_voltage_s1_q, input_bus_voltage_s2_q, input_bus_voltage_s3_q} <= {input_bus_voltage, input_bus_voltage_s1_q, input_bus_voltage_s2_q};
    end
  end

  wire scl_rise = scl_s2_q & ~scl_s3_q; // R16
  wire scl_fall = ~scl_s2_q & scl_s3_q; // R20
  wire bus_start = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q; // R18
  wire bus_stop = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q; // R18
  wire plug_in = input_bus_voltage_s2_q & ~input_bus_voltage_s3_q;

  // ----------------------------------------
  // wake button hold timer
  // ----------------------------------------
  // any high sample restarts the count, so short glitches never reach a threshold
  reg [27:0] btn_cnt_q;
  reg hold_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      btn_cnt_q <= 28'h0;
    end else if (btn_s2_q) begin
      btn_cnt_q <= 28'h0; // R25
    end else if (btn_cnt_q != 28'hfffffff) begin
      btn_cnt_q <= btn_cnt_q + 28'h1; // R25
    end
  end

  wire [27:0] exit_cyc = hold_q ? EXIT_SHORT_CYC : EXIT_LONG_CYC;
  wire btn_exit_hit = ~btn_s2_q & (btn_cnt_q == exit_cyc - 28'h1); // R4
  wire btn_rst_hit = ~btn_s2_q & (btn_cnt_q == BTN_RST_CYC - 28'h1); // R11

  // ----------------------------------------
  // control field and mode sequencer
  // ----------------------------------------
  reg [2:0] ps_q;
  reg [1:0] field_q;
  reg dly_q, regrst_q;
  reg [27:0] tmr_q;
  reg i2c_wr_q;
  reg [7:0] i2c_wdata_q;
  reg [3:0] aw_addr_q;
  reg [7:0] w_byte_q;
  reg w_lane0_q, aw_full_q, w_full_q;

  wire axi_do_wr = aw_full_q & w_full_q & ~bvalid;
  wire axi_ctrl_wr = axi_do_wr & (aw_addr_q == `AXI_CTRL_OFF) & w_lane0_q;
  wire wr_en = i2c_wr_q | axi_ctrl_wr;
  wire [7:0] wr_data = i2c_wr_q ? i2c_wdata_q : w_byte_q;
  wire [1:0] wr_mode = wr_data[`FLD_MODE_HI:`FLD_MODE_LO];
  wire [7:0] ctrl_byte = {regrst_q, 3'h0, hold_q, dly_q, field_q};
  wire [7:0] stat_byte = {4'h0, input_bus_voltage_s2_q, ps_q};

  reg [2:0] tgt;
  always @* begin
    case (field_q)
      `MODE_SHUTDOWN: tgt = P_SHUT; // R2
      `MODE_SHIP: tgt = P_SHIP; // R3
      `MODE_PRESET: tgt = P_RST; // R5 R13
      default: tgt = P_IDLE;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ps_q <= P_IDLE;
      field_q <= `MODE_RST; // R1
      dly_q <= `DLY_RST;
      hold_q <= `HOLD_RST;
      regrst_q <= 1'b0;
      tmr_q <= 28'h0;
    end else begin
      regrst_q <= 1'b0; // R23
      tmr_q <= 28'h0;
      // writes are dropped in shutdown: nothing but an adapter may wake it
      if (wr_en && ps_q != P_SHUT) begin
        if (wr_data[`FLD_RST]) begin
          field_q <= `MODE_RST; // R4
          dly_q <= `DLY_RST;
          hold_q <= `HOLD_RST;
          regrst_q <= 1'b1; // R23
        end else begin
          dly_q <= wr_data[`FLD_DLY];
          hold_q <= wr_data[`FLD_HOLD];
          if ((wr_mode == `MODE_SHUTDOWN || wr_mode == `MODE_SHIP) && input_bus_voltage_s2_q) begin
            field_q <= `MODE_IDLE; // R8 R9
          end else begin
            field_q <= wr_mode;
          end
        end
      end
      case (ps_q)
        P_IDLE: begin
          if (btn_rst_hit) begin
            field_q <= `MODE_PRESET; // R11
            ps_q <= P_RST;
          end else if (field_q != `MODE_IDLE) begin
            ps_q <= dly_q ? P_WAIT : tgt; // R7
          end
        end
        P_WAIT: begin
          if (field_q == `MODE_IDLE) begin
            ps_q <= P_IDLE;
          end else if (tmr_q == OFF_WAIT_CYC - 28'h1) begin
            ps_q <= tgt; // R7
          end else begin
            tmr_q <= tmr_q + 28'h1;
          end
        end
        P_SHUT: begin
          if (plug_in) begin
            field_q <= `MODE_RST; // R10
            ps_q <= P_IDLE;
          end
        end
        P_SHIP: begin
          if (field_q == `MODE_IDLE || plug_in || btn_exit_hit) begin
            field_q <= `MODE_RST; // R4
            ps_q <= P_IDLE;
          end
        end
        P_RST: begin
          if (tmr_q == PRESET_CYC - 28'h1) begin
            field_q <= `MODE_RST; // R5
            ps_q <= P_IDLE;
          end else begin
            tmr_q <= tmr_q + 28'h1;
          end
        end
        default: ps_q <= P_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // switch and mode outputs
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      ship_gate_drive <= 1'b1; // R1
      internal_battery_switch <= 1'b0;
      input_high_impedance <= 1'b0;
      sys_discharge_en <= 1'b0;
      i2c_enabled <= 1'b1;
      sys_clk_slow <= 1'b0;
      ship_switch_ctrl <= `MODE_RST;
    end else begin
      ship_gate_drive <= (ps_q == P_IDLE) || (ps_q == P_WAIT); // R1 R7
      if (ps_q == P_IDLE || ps_q == P_WAIT) begin
        internal_battery_switch <= charge_bat_req;
      end else if (ps_q != P_RST) begin
        internal_battery_switch <= 1'b0; // R2 R3 R6
      end
      input_high_impedance <= (ps_q == P_RST) & input_bus_voltage_s2_q; // R5
      sys_discharge_en <= (ps_q == P_RST); // R12
      i2c_enabled <= (ps_q != P_SHUT); // R2
      sys_clk_slow <= (ps_q == P_SHIP); // R3
      ship_switch_ctrl <= field_q;
    end
  end

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  // data is sampled on scl rise and driven on scl fall; no clock stretching is needed
  reg [2:0] ist_q, inxt_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q, ptr_q;
  reg rack_q;
  reg [7:0] i2c_rdata;

  always @* begin
    if (ptr_q > `I2C_LAST_REG) begin
      i2c_rdata = `I2C_OOR_DATA; // R15
    end else if (ptr_q == `I2C_CTRL_REG) begin
      i2c_rdata = ctrl_byte;
    end else if (ptr_q == `I2C_STAT_REG) begin
      i2c_rdata = stat_byte;
    end else begin
      i2c_rdata = 8'h00;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn || !i2c_enabled) begin
      ist_q <= I_IDLE;
      inxt_q <= I_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rack_q <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_o <= 1'b0;
      i2c_wr_q <= 1'b0;
      i2c_wdata_q <= 8'h00;
    end else begin
      i2c_wr_q <= 1'b0;
      if (bus_start) begin
        ist_q <= I_ADDR; // R26
        bit_q <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (bus_stop) begin
        ist_q <= I_IDLE; // R26
        sda_oe_n <= 1'b1;
      end else begin
        case (ist_q)
          I_ADDR, I_PTR, I_WDATA: begin
            if (scl_rise && bit_q != 4'h8) begin
              sh_q <= {sh_q[6:0], sda_s2_q}; // R17 R19
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (ist_q == I_ADDR) begin
                if (sh_q[7:1] == `I2C_DEV_ADDR) begin
                  sda_oe_n <= 1'b0; // R14
                  ist_q <= I_ACK;
                  inxt_q <= sh_q[0] ? I_RDATA : I_PTR; // R24
                end else begin
                  ist_q <= I_IDLE;
                end
              end else if (ist_q == I_PTR) begin
                if (sh_q <= `I2C_LAST_REG) begin
                  ptr_q <= sh_q;
                  sda_oe_n <= 1'b0;
                  ist_q <= I_ACK;
                  inxt_q <= I_WDATA;
                end else begin
                  ist_q <= I_IDLE; // R21
                end
              end else begin
                i2c_wr_q <= (ptr_q == `I2C_CTRL_REG);
                i2c_wdata_q <= sh_q;
                ptr_q <= ptr_q + 8'h01; // R22
                sda_oe_n <= 1'b0;
                ist_q <= I_ACK;
                inxt_q <= I_WDATA;
              end
            end
          end
          I_ACK: begin
            if (scl_fall) begin
              ist_q <= inxt_q;
              if (inxt_q == I_RDATA) begin
                sh_q <= {i2c_rdata[6:0], 1'b0};
                sda_oe_n <= i2c_rdata[7]; // R19
                bit_q <= 4'h1;
              end else begin
                sda_oe_n <= 1'b1;
              end
            end
          end
          I_RDATA: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                sda_oe_n <= 1'b1;
                ptr_q <= ptr_q + 8'h01; // R22
                rack_q <= 1'b0;
                ist_q <= I_RACK;
              end else begin
                sda_oe_n <= sh_q[7]; // R17
                sh_q <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          I_RACK: begin
            if (scl_rise) begin
              rack_q <= ~sda_s2_q;
            end else if (scl_fall) begin
              if (rack_q) begin
                sh_q <= {i2c_rdata[6:0], 1'b0};
                sda_oe_n <= i2c_rdata[7]; // R22
                bit_q <= 4'h1;
                ist_q <= I_RDATA;
              end else begin
                ist_q <= I_IDLE;
              end
            end
          end
          default: ist_q <= I_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // register bus slave
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else begin
      awready <= aw_full_q ? axi_do_wr : ~(awvalid & awready);
      wready <= w_full_q ? axi_do_wr : ~(wvalid & wready);
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
        aw_full_q <= 1'b1;
      end
      if (wvalid && wready) begin
        w_byte_q <= wdata[7:0];
        w_lane0_q <= wstrb[0];
        w_full_q <= 1'b1;
      end
      if (axi_do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid <= 1'b1;
        // the status word is read only; writing it is accepted and ignored
        if (aw_addr_q == `AXI_CTRL_OFF || aw_addr_q == `AXI_STAT_OFF) begin
          bresp <= `RESP_OKAY;
        end else begin
          bresp <= `RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `RESP_OKAY;
        if (araddr == `AXI_CTRL_OFF) begin
          rdata <= {24'h0, ctrl_byte};
        end else if (araddr == `AXI_STAT_OFF) begin
          rdata <= {24'h0, stat_byte};
        end else begin
          rdata <= 32'h0;
          rresp <= `RESP_SLVERR;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

endmodule // ship_switch_power_ctrl

/* rtl/ship_switch_power_ctrl_defs.vh */
// constants for the ship switch power controller
`ifndef SHIP_SWITCH_POWER_CTRL_DEFS_VH
`define SHIP_SWITCH_POWER_CTRL_DEFS_VH

// ----------------------------------------
// serial slave
// ----------------------------------------
`define I2C_DEV_ADDR 7'h6b
`define I2C_LAST_REG 8'h25
`define I2C_OOR_DATA 8'hff
`define I2C_CTRL_REG 8'h14
`define I2C_STAT_REG 8'h1b

// ----------------------------------------
// register bus offsets and answers
// ----------------------------------------
`define AXI_CTRL_OFF 4'h0
`define AXI_STAT_OFF 4'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// control byte layout and reset values
// ----------------------------------------
`define FLD_MODE_LO 0
`define FLD_MODE_HI 1
`define FLD_DLY 2
`define FLD_HOLD 3
`define FLD_RST 7
`define MODE_RST 2'h0
`define DLY_RST 1'b0
`define HOLD_RST 1'b0

// ----------------------------------------
// mode encodings
// ----------------------------------------
`define MODE_IDLE 2'h0
`define MODE_SHUTDOWN 2'h1
`define MODE_SHIP 2'h2
`define MODE_PRESET 2'h3

// ----------------------------------------
// timing, in ms, and clock rate in kHz
// ----------------------------------------
`define CLK_KHZ 20000
`define OFF_WAIT_MS 10000
`define EXIT_LONG_MS 1000
`define EXIT_SHORT_MS 15
`define PRESET_OFF_MS 350
`define BTN_RST_MS 10000

`endif

/* testbench/i2c_host_model.sv */
// serial bus master model that clocks the controller's serial slave port
`timescale 1ns/100ps
module i2c_host_model (
  input wire aclk, // system clock
  input wire sda, // resolved data line
  output logic scl, // clock line, this master is its only driver
  output logic sda_low // high pulls the data line low
);
  // ----------------------------------------
  // bit level
  // ----------------------------------------
  // 61 clocks a bit keeps the rate below the 400 kbit/s fast mode limit
  localparam int HALF = 30;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half_wait();
    repeat (HALF) @(posedge aclk);
  endtask
  // also a repeated start; the slave never stretches, so scl is simply let go
  task automatic start_c();
    sda_low <= 1'b0;
    half_wait();
    scl <= 1'b1;
    half_wait();
    sda_low <= 1'b1;
    half_wait();
    scl <= 1'b0;
    half_wait();
  endtask
  task automatic stop_c();
    sda_low <= 1'b1;
    half_wait();
    scl <= 1'b1;
    half_wait();
    sda_low <= 1'b0;
    half_wait();
  endtask
  task automatic bit_io(input logic d, output logic q);
    sda_low <= !d;
    half_wait();
    scl <= 1'b1;
    half_wait();
    q = sda;
    scl <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ao, output logic [7:0] rx, output logic ai);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ao, ai);
  endtask
endmodule // i2c_host_model

/* testbench/ship_switch_power_ctrl_asserts.sv */
// port checks for the ship switch power controller
`timescale 1ns/100ps
module ship_switch_power_ctrl_asserts #(
  parameter [27:0] PRESET_CYC = 28'd50
) (
  input wire aclk, // clock
  input wire aresetn, // sync reset, low active
  input wire scl_i, // serial clock level
  input wire sda_oe_n, // data pull, low active
  input wire ship_gate_drive, // ship switch on
  input wire internal_battery_switch, // battery switch on
  input wire input_high_impedance, // input in high impedance
  input wire sys_discharge_en, // rail sink on
  input wire i2c_enabled, // serial slave alive
  input wire sys_clk_slow, // clock slowed
  input wire [1:0] ship_switch_ctrl // control field
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // slack of a few cycles: the sequencer and the outputs are registered apart
  localparam int PLO = PRESET_CYC - 3;
  localparam int PHI = PRESET_CYC + 3;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_sink_gate_off: assert property (sys_discharge_en |-> !ship_gate_drive)
    else $error("sink on while ship switch on");
  chk_hiz_in_reset: assert property (input_high_impedance |-> sys_discharge_en)
    else $error("input high impedance outside power reset");
  chk_shut_all_off: assert property (!i2c_enabled |-> !ship_gate_drive && !internal_battery_switch && sda_oe_n)
    else $error("shutdown with a switch on or data driven");
  chk_ship_slow_on: assert property (sys_clk_slow |-> !ship_gate_drive && !internal_battery_switch && i2c_enabled)
    else $error("slow clock outside ship state");
  chk_bat_frozen: assert property (sys_discharge_en && $past(sys_discharge_en) |-> $stable(internal_battery_switch))
    else $error("battery switch moved in power reset");
  chk_reset_length: assert property ($rose(sys_discharge_en) |-> ##[PLO:PHI] $fell(sys_discharge_en))
    else $error("power reset off time wrong");
  chk_reset_end_idle: assert property ($fell(sys_discharge_en) |-> ##[0:3] (ship_gate_drive && ship_switch_ctrl == 2'h0))
    else $error("power reset did not return to idle");
  chk_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("data drive changed while clock high");

  cover property ($rose(sys_discharge_en));
  cover property ($rose(sys_clk_slow));
  cover property ($fell(sda_oe_n));
  cover property ($fell(i2c_enabled));
endmodule // ship_switch_power_ctrl_asserts

/* testbench/ship_switch_power_ctrl_tb.sv */
// self-checking bench for the ship switch power controller
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
`define WAIT(c, n) begin k = 0; do begin @(posedge aclk); k++; end while (!(c) && k < n); \
  if (!(c)) begin err_total++; $display("CHECK FAILED %0t timeout", $time); conclude(); end end
module ship_switch_power_ctrl_tb;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic wake_button_n = 1'b1, input_bus_voltage = 1'b0, charge_bat_req = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, sda_o, sda_oe_n, scl, m_low, ack;
  logic ship_gate_drive, internal_battery_switch, input_high_impedance;
  logic sys_discharge_en, i2c_enabled, sys_clk_slow;
  logic [1:0] bresp, rresp, ship_switch_ctrl;
  logic [31:0] rdata;
  logic [7:0] rx;
  int err_total = 0, num_checks = 0, k;
  // open drain with pull-up
  wire sda = !m_low & (sda_oe_n | sda_o);
  wire [7:0] pv = {ship_gate_drive, internal_battery_switch, i2c_enabled, sys_clk_slow,
    sys_discharge_en, input_high_impedance, ship_switch_ctrl};

  ship_switch_power_ctrl #(.OFF_WAIT_CYC(28'd200), .EXIT_LONG_CYC(28'd100), .EXIT_SHORT_CYC(28'd30),
    .PRESET_CYC(28'd50), .BTN_RST_CYC(28'd300)) u_ship_switch_power_ctrl (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_n,
    .wake_button_n, .input_bus_voltage, .charge_bat_req, .ship_gate_drive, .internal_battery_switch,
    .input_high_impedance, .sys_discharge_en, .i2c_enabled, .sys_clk_slow, .ship_switch_ctrl);
  i2c_host_model u_i2c_host_model (.aclk, .sda, .scl, .sda_low(m_low));

  initial forever #25 aclk = ~aclk;

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    // address and data may be taken on different edges
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end while ((awvalid || wvalid) && k < 20);
    if (awvalid || wvalid) begin
      err_total++;
      $display("CHECK FAILED %0t timeout", $time);
      conclude();
    end
    `WAIT(bvalid, 20)
    bready <= 1'b0;
    `CHK(bresp, r)
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    // one edge between reads keeps rready from being set and cleared in one step
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    `WAIT(arready, 20)
    arvalid <= 1'b0;
    `WAIT(rvalid, 20)
    rready <= 1'b0;
    `CHK(rdata, {24'h0, d})
    `CHK(rresp, r)
  endtask
  task automatic st();
    u_i2c_host_model.start_c();
  endtask
  task automatic sp();
    u_i2c_host_model.stop_c();
  endtask
  task automatic tx(input logic [7:0] b, input logic ao, input logic ea);
    u_i2c_host_model.xfer(b, ao, rx, ack);
    `CHK(ack, ea)
  endtask
  task automatic i2c_wr(input logic [7:0] p, input logic [7:0] d);
    st();
    tx(8'hd6, 1'b1, 1'b0);
    tx(p, 1'b1, 1'b0);
    tx(d, 1'b1, 1'b0);
    sp();
  endtask
  task automatic i2c_rd(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1);
    st();
    tx(8'hd6, 1'b1, 1'b0);
    tx(p, 1'b1, 1'b0);
    st();
    tx(8'hd7, 1'b1, 1'b0);
    tx(8'hff, 1'b0, 1'b0);
    `CHK(rx, e0)
    tx(8'hff, 1'b1, 1'b1);
    `CHK(rx, e1)
    sp();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wt(6);
    `CHK(pv, 8'he0)
    axi_rd(4'h0, 8'h00, 2'h0);
    axi_rd(4'h8, 8'h00, 2'h2);
    axi_wr(4'hc, 8'h01, 2'h2);
    wstrb <= 4'he;
    axi_wr(4'h0, 8'h01, 2'h0);
    wstrb <= 4'hf;
    wt(3);
    `CHK(pv, 8'he0)
    i2c_wr(8'h14, 8'h08);
    i2c_rd(8'h14, 8'h08, 8'h00);
    i2c_rd(8'h25, 8'h00, 8'hff);
    st();
    tx(8'hd6, 1'b1, 1'b0);
    tx(8'h30, 1'b1, 1'b1);
    sp();
    st();
    tx(8'hd4, 1'b1, 1'b1);
    sp();
    i2c_wr(8'h14, 8'h0a);
    wt(5);
    `CHK(pv, 8'h32)
    axi_rd(4'h4, 8'h03, 2'h0);
    repeat (2) begin
      wake_button_n <= 1'b0;
      wt(20);
      wake_button_n <= 1'b1;
      wt(3);
    end
    `CHK(pv, 8'h32)
    wake_button_n <= 1'b0;
    wt(40);
    wake_button_n <= 1'b1;
    wt(5);
    `CHK(pv, 8'he0)
    axi_wr(4'h0, 8'h02, 2'h0);
    wt(5);
    wake_button_n <= 1'b0;
    wt(80);
    `CHK(pv, 8'h32)
    wt(40);
    wake_button_n <= 1'b1;
    wt(5);
    `CHK(pv, 8'he0)
    // exits by field write, register reset and adapter plug-in
    for (int e = 0; e < 3; e++) begin
      axi_wr(4'h0, 8'h02, 2'h0);
      wt(5);
      if (e == 2) input_bus_voltage <= 1'b1;
      else axi_wr(4'h0, e ? 8'h80 : 8'h00, 2'h0);
      wt(8);
      `CHK(pv, 8'he0)
    end
    axi_rd(4'h0, 8'h00, 2'h0);
    axi_wr(4'h0, 8'h01, 2'h0);
    wt(5);
    `CHK(pv, 8'he0)
    axi_wr(4'h0, 8'h02, 2'h0);
    wt(5);
    `CHK(pv, 8'he0)
    axi_wr(4'h0, 8'h07, 2'h0);
    wt(100);
    `CHK(pv, 8'he3)
    `WAIT(sys_discharge_en, 200)
    charge_bat_req <= 1'b0;
    wt(3);
    `CHK(pv, 8'h6f)
    `WAIT(!sys_discharge_en, 80)
    wt(3);
    `CHK(pv, 8'ha0)
    charge_bat_req <= 1'b1;
    input_bus_voltage <= 1'b0;
    wake_button_n <= 1'b0;
    wt(250);
    `CHK(sys_discharge_en, 1'b0)
    `WAIT(sys_discharge_en, 150)
    wt(2);
    `CHK(pv, 8'h6b)
    wake_button_n <= 1'b1;
    `WAIT(!sys_discharge_en, 80)
    wt(3);
    `CHK(pv, 8'he0)
    axi_wr(4'h0, 8'h01, 2'h0);
    wt(5);
    `CHK(pv, 8'h01)
    st();
    tx(8'hd6, 1'b1, 1'b1);
    sp();
    axi_wr(4'h0, 8'h00, 2'h0);
    wt(5);
    `CHK(pv, 8'h01)
    input_bus_voltage <= 1'b1;
    wt(8);
    `CHK(pv, 8'he0)
    conclude();
  end
endmodule // ship_switch_power_ctrl_tb

bind ship_switch_power_ctrl ship_switch_power_ctrl_asserts #(.PRESET_CYC(PRESET_CYC))
  u_ship_switch_power_ctrl_asserts (.aclk, .aresetn, .scl_i, .sda_oe_n, .ship_gate_drive,
  .internal_battery_switch, .input_high_impedance, .sys_discharge_en, .i2c_enabled, .sys_clk_slow,
  .ship_switch_ctrl);
